/* File: logic/sdr_pkg.sv */
// Shared constants for the self-diagnosis result formatter
package sdr_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Control register fields
  localparam int CTRL_ALIGN_BIT = 0;
  localparam int CTRL_RES_LSB   = 1;
  localparam int CTRL_RES_W     = 2;

  // Status register fields
  localparam int STAT_VALID_BIT   = 0;
  localparam int STAT_OVERRUN_BIT = 1;

  // Converter, result and bus data widths
  localparam int CONV_W   = 12;
  localparam int DIAG_W   = 2;
  localparam int RESULT_W = 16;
  localparam int APB_DW   = 32;

  // Resolution codes held in the control register
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;

  // Alignment codes
  localparam logic ALIGN_RIGHT = 1'h0;
  localparam logic ALIGN_LEFT  = 1'h1;

  // Reset values
  localparam logic       RST_ALIGN  = ALIGN_RIGHT;
  localparam logic [1:0] RST_RES    = RES_12;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  // A resolution code the formatter can serve
  function automatic logic res_ok(input logic [1:0] res);
    res_ok = (res == RES_12) || (res == RES_10) || (res == RES_8);
  endfunction

endpackage

/* File: logic/sdr_pack.sv */
// Packs converted value and diagnosis status into the result word
`timescale 1ns/100ps
module sdr_pack (
  input  wire logic                         i_align,
  input  wire logic [1:0]                   i_res,
  input  wire logic [sdr_pkg::CONV_W-1:0]   i_data,
  input  wire logic [sdr_pkg::DIAG_W-1:0]   i_diag,
  output logic      [sdr_pkg::RESULT_W-1:0] o_word
);
  import sdr_pkg::*;

  // Unused bits stay zero in every layout
  always_comb begin
    o_word = RST_RESULT;
    if (i_align == ALIGN_LEFT) begin
      o_word[1:0] = i_diag;
      case (i_res)
        RES_10: begin
          o_word[15:6] = i_data[9:0];
        end
        RES_8: begin
          o_word[15:8] = i_data[7:0];
        end
        default: begin
          o_word[15:4] = i_data;
        end
      endcase
    end else begin
      o_word[15:14] = i_diag;
      case (i_res)
        RES_10: begin
          o_word[9:0] = i_data[9:0];
        end
        RES_8: begin
          o_word[7:0] = i_data[7:0];
        end
        default: begin
          o_word[11:0] = i_data;
        end
      endcase
    end
  end

endmodule

/* File: logic/sdr_top.sv */
// Self-diagnosis result register with APB access
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module sdr_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                         i_clock,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_clock_en,
  input  wire logic                         i_conv_valid,
  input  wire logic [sdr_pkg::CONV_W-1:0]   i_conv_data,
  input  wire logic [sdr_pkg::DIAG_W-1:0]   i_diag_status,
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [ADDR_W-1:0]            i_paddr,
  input  wire logic [sdr_pkg::APB_DW-1:0]   i_pwdata,
  output logic      [sdr_pkg::APB_DW-1:0]   o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  output logic      [sdr_pkg::RESULT_W-1:0] o_result,
  output logic                              o_result_valid
);
  import sdr_pkg::*;

  // Offsets must fit the address bus
  generate
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 4 and 32");
    end
  endgenerate

  typedef struct packed {
    logic                align;
    logic [1:0]          res;
    logic [RESULT_W-1:0] result;
    logic                valid;
    logic                overrun;
    logic                pready;
    logic                pslverr;
    logic [APB_DW-1:0]   prdata;
  } sdr_state_s;

  sdr_state_s          st_q;
  sdr_state_s          st_d;
  logic                rst_meta_q;
  logic                rst_n_q;
  logic [RESULT_W-1:0] packed_word;
  logic [7:0]          word_addr;
  logic                setup;
  logic                access;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'h0;
      rst_n_q    <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Layout follows the live configuration at the store
  sdr_pack u_pack (
    .i_align (st_q.align),
    .i_res   (st_q.res),
    .i_data  (i_conv_data),
    .i_diag  (i_diag_status),
    .o_word  (packed_word)
  );

  // Highest paddr bit that takes part in the register decode
  localparam int DEC_MSB = (ADDR_W > 8) ? 7 : ADDR_W - 1;

  // Address decode; upper bits above the map must be zero
  always_comb begin
    word_addr = 8'h00;
    word_addr[DEC_MSB:0] = i_paddr[DEC_MSB:0];
  end

  assign setup  = i_psel && !i_penable && !st_q.pready;
  assign access = i_psel && i_penable && st_q.pready;

  // Next-state logic for bus, configuration and stored result
  always_comb begin
    st_d         = st_q;
    st_d.pready  = 1'h0;
    st_d.pslverr = 1'h0;
    // Read data and error are decided in setup, shown in access
    if (setup) begin
      st_d.pready = 1'h1;
      st_d.prdata = '0;
      if (ADDR_W > 8 && (i_paddr >> 8) != '0) begin
        st_d.pslverr = 1'h1;
      end else if (i_pwrite) begin
        // Result and status are read-only; bad resolution refused
        st_d.pslverr = (word_addr != OFS_CTRL) ||
          !res_ok(i_pwdata[CTRL_RES_LSB +: CTRL_RES_W]);
      end else begin
        case (word_addr)
          OFS_CTRL: begin
            st_d.prdata[CTRL_ALIGN_BIT] = st_q.align;
            st_d.prdata[CTRL_RES_LSB +: CTRL_RES_W] = st_q.res;
          end
          OFS_RESULT: begin
            st_d.prdata[RESULT_W-1:0] = st_q.result;
            // Clear on read happens here, before a store can set it
            st_d.valid   = 1'h0;
            st_d.overrun = 1'h0;
          end
          OFS_STATUS: begin
            st_d.prdata[STAT_VALID_BIT]   = st_q.valid;
            st_d.prdata[STAT_OVERRUN_BIT] = st_q.overrun;
          end
          default: begin
            st_d.pslverr = 1'h1;
          end
        endcase
      end
    end
    // Write lands at the edge where the master sees pready
    if (access && i_pwrite && !st_q.pslverr) begin
      st_d.align = i_pwdata[CTRL_ALIGN_BIT];
      st_d.res   = i_pwdata[CTRL_RES_LSB +: CTRL_RES_W];
    end
    // Store wins over a clear in the same cycle
    if (i_conv_valid) begin
      st_d.result  = packed_word;
      st_d.overrun = st_q.valid && st_d.valid;
      st_d.valid   = 1'h1;
    end
  end

  // Single state register, frozen while the clock enable is low
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q        <= '0;
      st_q.align  <= RST_ALIGN;
      st_q.res    <= RST_RES;
      st_q.result <= RST_RESULT;
    end else if (i_clock_en) begin
      st_q <= st_d;
    end
  end

  assign o_prdata       = st_q.prdata;
  assign o_pready       = st_q.pready;
  assign o_pslverr      = st_q.pslverr;
  assign o_result       = st_q.result;
  assign o_result_valid = st_q.valid;

  // Shorthand for a store under a given layout
  logic store;
  assign store = i_clock_en && i_conv_valid;

  AST_LEFT_12: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (store && st_q.align == ALIGN_LEFT && st_q.res == RES_12)
    |=> o_result == {$past(i_conv_data), 2'h0, $past(i_diag_status)})
    else $error("left 12-bit layout wrong");

  AST_RIGHT_8: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (store && st_q.align == ALIGN_RIGHT && st_q.res == RES_8)
    |=> o_result == {$past(i_diag_status), 6'h00,
                     $past(i_conv_data[7:0])})
    else $error("right 8-bit layout wrong");

  AST_LEFT_10: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (store && st_q.align == ALIGN_LEFT && st_q.res == RES_10)
    |=> o_result == {$past(i_conv_data[9:0]), 4'h0,
                     $past(i_diag_status)})
    else $error("left 10-bit layout wrong");

  AST_LEFT_8: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (store && st_q.align == ALIGN_LEFT && st_q.res == RES_8)
    |=> o_result == {$past(i_conv_data[7:0]), 6'h00,
                     $past(i_diag_status)})
    else $error("left 8-bit layout wrong");

  AST_RIGHT_12: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (store && st_q.align == ALIGN_RIGHT && st_q.res == RES_12)
    |=> o_result == {$past(i_diag_status), 2'h0, $past(i_conv_data)})
    else $error("right 12-bit layout wrong");

  AST_RIGHT_10: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (store && st_q.align == ALIGN_RIGHT && st_q.res == RES_10)
    |=> o_result == {$past(i_diag_status), 4'h0,
                     $past(i_conv_data[9:0])})
    else $error("right 10-bit layout wrong");

  AST_HOLD_RESULT: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    !store |=> $stable(o_result))
    else $error("result changed without a store");

  AST_VALID_SET: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    store |=> o_result_valid)
    else $error("store did not raise valid");

  AST_PREADY_PULSE: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (i_clock_en && setup) |=> o_pready ##1 (!$past(i_clock_en) || !o_pready))
    else $error("pready not a single-cycle answer");

  // Error only ever travels with the answer strobe
  AST_ERR_WITH_READY: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    o_pslverr |-> o_pready)
    else $error("pslverr without pready");

  // Result read shows the stored word in the low half, upper half zero
  AST_RESULT_READ: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (i_clock_en && setup && !i_pwrite && word_addr == OFS_RESULT &&
     (i_paddr >> 8) == '0)
    |=> o_prdata == {16'h0, $past(o_result)})
    else $error("result read data wrong");

  // An accepted control write changes the resolution at its access edge
  AST_CTRL_WRITE: assert property (
    @(posedge i_clock) disable iff (!rst_n_q)
    (i_clock_en && access && i_pwrite && !o_pslverr)
    |=> st_q.res == $past(i_pwdata[CTRL_RES_LSB +: CTRL_RES_W]))
    else $error("control write did not land");

  COV_LEFT_STORE: cover property (
    @(posedge i_clock) disable iff (!rst_n_q)
    store && st_q.align == ALIGN_LEFT);

  COV_RIGHT_8_STORE: cover property (
    @(posedge i_clock) disable iff (!rst_n_q)
    store && st_q.align == ALIGN_RIGHT && st_q.res == RES_8);

  COV_RESULT_READ: cover property (
    @(posedge i_clock) disable iff (!rst_n_q)
    access && !i_pwrite && word_addr == OFS_RESULT);

  COV_BAD_WRITE: cover property (
    @(posedge i_clock) disable iff (!rst_n_q)
    access && o_pslverr && i_pwrite);

endmodule

/* File: dv/sdr_top_test.sv */
// Self-checking bench for the self-diagnosis result register
`timescale 1ns/100ps
module sdr_top_test;
  import sdr_pkg::*;
  logic        i_clock;
  logic        i_reset_n;
  logic        i_clock_en;
  logic        i_conv_valid;
  logic [11:0] i_conv_data;
  logic [1:0]  i_diag_status;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic [15:0] o_result;
  logic        o_result_valid;
  int          bad_count;
  int          checks;
  int          cycles;
  logic [31:0] rd;
  logic        err;
  logic [31:0] w_exp;
  logic [31:0] w_seen;

  sdr_top #(.ADDR_W(8)) u_sdr_top (
    .i_clock        (i_clock),
    .i_reset_n      (i_reset_n),
    .i_clock_en     (i_clock_en),
    .i_conv_valid   (i_conv_valid),
    .i_conv_data    (i_conv_data),
    .i_diag_status  (i_diag_status),
    .i_psel         (i_psel),
    .i_penable      (i_penable),
    .i_pwrite       (i_pwrite),
    .i_paddr        (i_paddr),
    .i_pwdata       (i_pwdata),
    .o_prdata       (o_prdata),
    .o_pready       (o_pready),
    .o_pslverr      (o_pslverr),
    .o_result       (o_result),
    .o_result_valid (o_result_valid)
  );

  // 100 ns period
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // Expected word, worked out from alignment and resolution
  function automatic logic [15:0] pack(input logic        left,
                                       input logic [1:0]  res,
                                       input logic [11:0] d,
                                       input logic [1:0]  s);
    int          w;
    logic [15:0] v;
    w = (res == RES_12) ? 12 : (res == RES_10) ? 10 : 8;
    v = {4'h0, d} & ((16'h0001 << w) - 16'h0001);
    pack = left ? ((v << (16 - w)) | {14'h0, s}) : (v | {s, 14'h0});
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd);
    @(posedge i_clock);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= addr;
    i_pwdata  <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    // Wait as long as the slave needs; only the bench timeout ends it
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic set_cfg(input logic left, input logic [1:0] res);
    apb(1'b1, OFS_CTRL, {29'h0, res, left});
    check({31'h0, err}, 32'h0);
  endtask

  // One-cycle store strobe; result is looked at one edge later
  task automatic store(input logic [11:0] d, input logic [1:0] s);
    @(posedge i_clock);
    i_conv_valid  <= 1'b1;
    i_conv_data   <= d;
    i_diag_status <= s;
    @(posedge i_clock);
    i_conv_valid  <= 1'b0;
    @(posedge i_clock);
  endtask

  // Every alignment and resolution, two data patterns, port and bus view
  task automatic test_layouts();
    logic [11:0] dv[2];
    logic [1:0]  sv[2];
    dv = '{12'hB6D, 12'hFFF};
    sv = '{2'h2, 2'h3};
    for (int a = 0; a < 2; a++) begin
      for (int r = 0; r < 3; r++) begin
        for (int k = 0; k < 2; k++) begin
          w_exp = {16'h0, pack(a[0], r[1:0], dv[k], sv[k])};
          set_cfg(a[0], r[1:0]);
          store(dv[k], sv[k]);
          w_seen = {16'h0, o_result};
          check(w_seen, w_exp);
          check({31'h0, o_result_valid}, 32'h1);
          apb(1'b0, OFS_RESULT, 32'h0);
          check(rd, w_exp);
        end
      end
    end
    $display("test layouts done");
  endtask

  // Refused writes leave the layout alone
  task automatic test_refused();
    set_cfg(1'b1, RES_10);
    apb(1'b1, OFS_RESULT, 32'hFFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h7);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    w_exp = {16'h0, pack(1'b1, RES_10, 12'h3C7, 2'h1)};
    store(12'h3C7, 2'h1);
    w_seen = {16'h0, o_result};
    check(w_seen, w_exp);
    // Second store on an unread result raises overrun
    store(12'h3C7, 2'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, OFS_RESULT, 32'h0);
    check(rd, w_exp);
    check({31'h0, o_result_valid}, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    $display("test refused done");
  endtask

  // Stored word keeps the layout of its store edge
  task automatic test_hold();
    set_cfg(1'b1, RES_12);
    store(12'h9A4, 2'h2);
    w_exp = {16'h0, pack(1'b1, RES_12, 12'h9A4, 2'h2)};
    set_cfg(1'b0, RES_8);
    @(posedge i_clock);
    w_seen = {16'h0, o_result};
    check(w_seen, w_exp);
    i_clock_en <= 1'b0;
    store(12'h123, 2'h1);
    i_clock_en <= 1'b1;
    w_seen = {16'h0, o_result};
    check(w_seen, w_exp);
    store(12'h9A4, 2'h2);
    w_exp = {16'h0, pack(1'b0, RES_8, 12'h9A4, 2'h2)};
    w_seen = {16'h0, o_result};
    check(w_seen, w_exp);
    $display("test hold done");
  endtask

  // Mid-run reset brings result, valid flag and layout back to reset values
  task automatic test_reset();
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    w_seen = {16'h0, o_result};
    check(w_seen, {16'h0, RST_RESULT});
    check({31'h0, o_result_valid}, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, {29'h0, RST_RES, RST_ALIGN});
    check({31'h0, err}, 32'h0);
    $display("test reset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, far above the under two hundred cycles the tests need
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    bad_count = 0;
    checks = 0;
    cycles = 0;
    i_reset_n = 1'b0;
    i_clock_en = 1'b1;
    i_conv_valid = 1'b0;
    i_conv_data = 12'h000;
    i_diag_status = 2'h0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    test_layouts();
    test_refused();
    test_hold();
    test_reset();
    wrap_up();
  end
endmodule
